// ### bench/tcp_search_model.sv
// Purpose: Table search stand-in answering after a delay
// Assumes: One search outstanding
// Notes: Result lines toggle while not valid

`timescale 1ns/10ps

module tcp_search_model
	import tcp_pkg::*;
	#(parameter int DLY = 3)
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic search_req_in,
	input wire tcp_pkg::tcp_result_s cfg_in,
	output logic done_out,
	output tcp_pkg::tcp_result_s result_out
);
	// ********
	// Search
	// ********
	int cnt;
	wire logic fire = !search_req_in && cnt == 1;
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			cnt <= 0;
			done_out <= 1'b0;
			result_out <= '0;
		end else begin
			done_out <= fire;
			result_out <= fire ? cfg_in : ~result_out;
			if (search_req_in) begin
				cnt <= DLY;
			end else if (cnt > 0) begin
				cnt <= cnt - 1;
			end
		end
	end
endmodule : tcp_search_model

// ### bench/tcp_translation_cache_checker.sv
// Purpose: Port checks of the translation cache
// Assumes: Single clock, synchronous reset
// Notes: Bound into every cache instance

`timescale 1ns/10ps

module tcp_translation_cache_checker
	import tcp_pkg::*;
(
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic [31:0] supervisor_root_pointer_in,
	input wire logic [31:0] user_root_pointer_in,
	input wire logic req_valid_in,
	input wire tcp_pkg::tcp_req_s req_in,
	input wire logic busy_out,
	input wire logic resp_valid_out,
	input wire tcp_pkg::tcp_resp_s resp_out,
	input wire logic search_req_out,
	input wire tcp_pkg::tcp_search_s search_out,
	input wire logic user_page_attr_out0,
	input wire logic user_page_attr_out1
);
	// ********
	// Checks
	// ********
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (sys_rst_in);
	sequence s_take;
		req_valid_in && !busy_out;
	endsequence
	sequence s_miss;
		resp_valid_out && resp_out.retry;
	endsequence
	chk_one_answer: assert property (s_take |=> resp_valid_out)
		else $error("request not answered");
	chk_busy_refuse: assert property (req_valid_in && busy_out |=> !resp_valid_out)
		else $error("answer while busy");
	chk_bypass_map: assert property (s_take ##0 req_in.alternate_space_move
		|=> resp_out.phys_addr == $past(req_in.logical_addr)
		&& resp_out.cache_mode_field == 2'h3)
		else $error("bypass address wrong");
	chk_mode_decode: assert property (resp_valid_out && resp_out.hit
		|-> resp_out.cachable
		== !resp_out.cache_mode_field[1] && resp_out.copyback
		== (resp_out.cache_mode_field == 2'h1) && resp_out.serialized
		== (resp_out.cache_mode_field == 2'h2))
		else $error("cache mode decode wrong");
	chk_root_select: assert property (search_req_out |-> search_out.root_pointer
		== (search_out.supervisor ? supervisor_root_pointer_in
		: user_root_pointer_in))
		else $error("wrong root pointer");
	chk_miss_search: assert property (s_miss |-> search_req_out && busy_out)
		else $error("retry without search");
	chk_err_quiet: assert property (resp_valid_out && resp_out.access_error
		|-> !search_req_out)
		else $error("search on access error");
	chk_attr_pulse: assert property (user_page_attr_out0 || user_page_attr_out1
		|-> resp_valid_out && resp_out.hit)
		else $error("attribute outside hit");
	chk_page_offset: assert property (s_take ##0 !req_in.alternate_space_move
		##1 resp_out.hit |-> resp_out.phys_addr[11:0]
		== $past(req_in.logical_addr[11:0]))
		else $error("page offset changed");
endmodule : tcp_translation_cache_checker

bind tcp_translation_cache tcp_translation_cache_checker tcp_chk_i (.*);

// ### bench/translation_cache_protection_bench.sv
// Purpose: Directed tests of the translation cache
// Assumes: Search model answers every search
// Notes: Checks run through one compare task

`timescale 1ns/10ps

module translation_cache_protection_bench;
	import tcp_pkg::*;
	// ********
	// Wiring
	// ********
	logic clk_sys_in = 0, sys_rst_in = 1, page_8k_in = 0;
	logic req_valid_in = 0, flush_valid_in = 0, search_done_in;
	logic busy_out, resp_valid_out, search_req_out;
	logic user_page_attr_out0, user_page_attr_out1;
	logic [31:0] supervisor_root_pointer_in = 32'h5000;
	logic [31:0] user_root_pointer_in = 32'h9000;
	logic [1:0] u;
	tcp_req_s req_in = '0;
	tcp_flush_s flush_in = '0;
	tcp_result_s search_result_in, res;
	tcp_resp_s resp_out, r;
	tcp_search_s search_out;
	int err_total = 0, checks_done = 0;
	localparam logic [31:0] LA = 32'h12345678;
	localparam logic [31:0] LB = 32'h1000;
	tcp_translation_cache tcp_translation_cache_i (
		.clk_sys_in(clk_sys_in),
		.sys_rst_in(sys_rst_in),
		.page_8k_in(page_8k_in),
		.supervisor_root_pointer_in(supervisor_root_pointer_in),
		.user_root_pointer_in(user_root_pointer_in),
		.req_valid_in(req_valid_in),
		.req_in(req_in),
		.flush_valid_in(flush_valid_in),
		.flush_in(flush_in),
		.search_done_in(search_done_in),
		.search_result_in(search_result_in),
		.busy_out(busy_out),
		.resp_valid_out(resp_valid_out),
		.resp_out(resp_out),
		.search_req_out(search_req_out),
		.search_out(search_out),
		.user_page_attr_out0(user_page_attr_out0),
		.user_page_attr_out1(user_page_attr_out1)
	);
	tcp_search_model tcp_search_model_i (.clk_sys_in, .sys_rst_in,
		.search_req_in(search_req_out), .cfg_in(res),
		.done_out(search_done_in), .result_out(search_result_in));
	initial begin
		forever #2.5 clk_sys_in = ~clk_sys_in;
	end
	// ********
	// Tasks
	// ********
	task results;
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : results
	task chk(input string n, input logic [31:0] e, g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("FAIL %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task acc(input logic [31:0] a, input logic s, w, m, x);
		@(posedge clk_sys_in);
		req_valid_in <= 1;
		req_in <= '{a, s, w, m, x};
		@(posedge clk_sys_in);
		req_valid_in <= 0;
		#1;
		r = resp_out;
		u = {user_page_attr_out1, user_page_attr_out0};
		chk("resp_valid", 1, resp_valid_out);
	endtask : acc
	task fill(input logic [31:0] a, input logic s, w);
		int n;
		acc(a, s, w, 0, 1);
		chk("retry", 1, r.retry);
		for (n = 0; n < 50 && busy_out !== 0; n++) @(posedge clk_sys_in);
		if (n == 50) begin
			err_total++;
			results;
		end
		#1;
		acc(a, s, w, 0, 1);
	endtask : fill
	// ********
	// Tests
	// ********
	initial begin
		res = '{20'hABCDE, 2'h1, 0, 0, 0, 0, 1, 1, 1};
		repeat (6) @(posedge clk_sys_in);
		sys_rst_in <= 0;
		#1;
		chk("busy_rst", 0, busy_out);
		fill(LA, 0, 0);
		chk("root_user", 32'h9000, search_out.root_pointer);
		chk("search_la", LA, search_out.logical_addr);
		chk("phys", {20'hABCDE, LA[11:0]}, r.phys_addr);
		chk("upa", 3, u);
		res.modified = 1;
		fill(LA, 0, 1);
		chk("wr_hit", 1, r.hit);
		fill(LA, 1, 0);
		chk("root_sup", 32'h5000, search_out.root_pointer);
		$display("translate done");
		res = '{20'h11111, 2'h1, 1, 1, 0, 1, 1, 0, 0};
		fill(LB, 0, 0);
		chk("sup_only", 1, r.access_error);
		fill(LB, 1, 0);
		chk("sup_ok", 1, r.hit);
		res = '{20'h22222, 2'h1, 0, 0, 1, 0, 1, 0, 0};
		fill(32'h2000, 1, 1);
		chk("wp_wr", 1, r.access_error);
		acc(32'h2000, 1, 0, 0, 0);
		chk("wp_rd", 1, r.hit);
		res.resident = 0;
		fill(32'h3000, 0, 0);
		chk("nonres", 1, r.bus_error);
		res.resident = 1;
		acc(32'h13579BDF, 0, 1, 1, 0);
		chk("bypass", 32'h13579BDF, r.phys_addr);
		$display("protect done");
		for (int i = 0; i < 4; i++) begin
			res.cache_mode_field = i[1:0];
			fill(32'h800000 | (i << 12), 1, 0);
			chk("cm", {i[1:0], !i[1], i == 1, i == 2},
				{r.cache_mode_field, r.cachable, r.copyback, r.serialized});
		end
		@(posedge clk_sys_in);
		flush_valid_in <= 1;
		flush_in <= '{1, 1, 32'h0, 1'b0};
		@(posedge clk_sys_in);
		flush_valid_in <= 0;
		fill(LA, 0, 0);
		acc(LB, 1, 0, 0, 0);
		chk("global", 1, r.hit);
		@(posedge clk_sys_in);
		page_8k_in <= 1;
		fill(32'hA000000, 1, 0);
		acc(32'hA001000, 1, 0, 0, 0);
		chk("page8k", 32'h22223000, r.phys_addr);
		$display("flush done");
		results;
	end
endmodule : translation_cache_protection_bench

// ### inc/tcp_pkg.sv
// Purpose: Shared constants and carriers of the translation cache block
// Assumes: 32-bit logical and physical addresses
// Notes: Entry fields mirror the page descriptor attributes

package tcp_pkg;

	// *******************************************************
	// Geometry
	// *******************************************************
	localparam int TCP_WAYS = 4;
	localparam int TCP_SETS = 16;
	localparam int TCP_ENTRIES = 64;
	localparam int TCP_IDX_W = 6;
	localparam int TCP_SET_W = 4;
	localparam int TCP_TAG_W = 20;
	localparam int TCP_PAGE_LSB = 12;
	localparam int TCP_SET_LSB_4K = 12;
	localparam int TCP_SET_LSB_8K = 13;
	localparam logic [19:0] TCP_TAG_MASK_4K = 20'hFFFFF;
	localparam logic [19:0] TCP_TAG_MASK_8K = 20'hFFFFE;
	localparam logic [1:0] TCP_RESET_VICTIM = 2'h0;

	// *******************************************************
	// Cache mode field encodings
	// *******************************************************
	localparam logic [1:0] TCP_CM_WRITE_THROUGH = 2'h0;
	localparam logic [1:0] TCP_CM_COPYBACK = 2'h1;
	localparam logic [1:0] TCP_CM_NC_SERIAL = 2'h2;
	localparam logic [1:0] TCP_CM_NONCACHE = 2'h3;

	// *******************************************************
	// Types
	// *******************************************************
	typedef enum logic [1:0] {
		TCP_ST_IDLE = 2'h1,
		TCP_ST_SEARCH = 2'h2
	} tcp_state_e;

	typedef struct packed {
		logic [31:0] logical_addr;
		logic supervisor;
		logic write;
		logic alternate_space_move;
		logic ext_bus_xfer;
	} tcp_req_s;

	typedef struct packed {
		logic hit;
		logic retry;
		logic access_error;
		logic bus_error;
		logic [31:0] phys_addr;
		logic [1:0] cache_mode_field;
		logic cachable;
		logic copyback;
		logic serialized;
	} tcp_resp_s;

	typedef struct packed {
		logic [31:0] logical_addr;
		logic [31:0] root_pointer;
		logic supervisor;
		logic write;
	} tcp_search_s;

	typedef struct packed {
		logic [19:0] phys_page;
		logic [1:0] cache_mode_field;
		logic global;
		logic supervisor_only;
		logic write_protect;
		logic modified;
		logic resident;
		logic user_attr_bit1;
		logic user_attr_bit0;
	} tcp_result_s;

	typedef struct packed {
		logic all;
		logic nonglobal_only;
		logic [31:0] logical_addr;
		logic privilege_function_bit;
	} tcp_flush_s;

	typedef struct packed {
		logic valid;
		logic privilege_function_bit;
		logic [19:0] tag;
		tcp_result_s attr;
	} tcp_entry_s;

endpackage : tcp_pkg

// ### src/tcp_translation_cache.sv
// Purpose: Four-way translation cache with supervisor and write checks
// Assumes: Table search logic walks descriptors and returns one result
// Notes: Requests are ignored while a search is outstanding

`timescale 1ns/10ps

// Summary of operation
// [R1] Separate supervisor and user trees, chosen by privilege of the access.
// [R2] Write protect honoured from any level; page carries supervisor-only bit.
// [R3] Supervisor accesses search from the supervisor root pointer.
// [R4] Alternate-space alternate_space_move bypass translation and reach all memory.
// [R5] User search meeting supervisor-only page still creates entry with bit set.
// [R6] User access hitting supervisor-only entry raises access error.
// [R7] Supervisor-only clear allows both modes; set allows supervisor only.
// [R8] Write protect blocks every write, independent of supervisor-only.
// [R9] Any write-protect bit met in search sets entry write protect.
// [R10] Write hitting write-protected entry raises access error, no write.
// [R11] Sixteen sets of four ways, 64 translations with attributes.
// [R12] Entry holds tag, privilege bit, physical page and attributes.
// [R13] Cache mode field encodes write-through, copyback, serialized, noncachable.
// [R14] Privilege function bit stored and compared in tag match.
// [R15] Global entries survive nonglobal flushes.
// [R16] Tag compares bits 31-12, ignoring bit 12 for 8K pages.
// [R17] Valid write sets the entry modified bit.
// [R18] Write to unmodified entry searches, overwrites entry, then retries.
// [R19] Resident bit set only on error-free, resident search.
// [R20] Physical page bits replace logical page bits on a hit.
// [R21] Set index is bits 16-13 for 8K, 15-12 for 4K pages.
// [R22] Full set victim from 2-bit counter advanced on every access.
// [R23] Valid set on load, cleared by selecting flush.
// [R24] User attribute bits echoed on user page attribute outputs.
// [R25] Read of write-protected entry completes; protect beats modified search.
module tcp_translation_cache (
	input wire logic clk_sys_in,
	input wire logic sys_rst_in,
	input wire logic page_8k_in,
	input wire logic [31:0] supervisor_root_pointer_in,
	input wire logic [31:0] user_root_pointer_in,
	input wire logic req_valid_in,
	input wire tcp_pkg::tcp_req_s req_in,
	input wire logic flush_valid_in,
	input wire tcp_pkg::tcp_flush_s flush_in,
	input wire logic search_done_in,
	input wire tcp_pkg::tcp_result_s search_result_in,
	output logic busy_out,
	output logic resp_valid_out,
	output tcp_pkg::tcp_resp_s resp_out,
	output logic search_req_out,
	output tcp_pkg::tcp_search_s search_out,
	output logic user_page_attr_out0,
	output logic user_page_attr_out1
);
	import tcp_pkg::*;

	// *******************************************************
	// State
	// *******************************************************
	tcp_entry_s ent [TCP_ENTRIES];
	tcp_state_e state;
	logic [1:0] victim_cnt;
	logic [31:0] pend_la;
	logic pend_fc2;
	logic pend_update;
	logic [1:0] pend_way;

	// *******************************************************
	// Lookup
	// *******************************************************
	wire logic [31:0] la = req_in.logical_addr;
	wire logic req_fc2 = req_in.supervisor;
	wire logic [19:0] tag_mask = page_8k_in ? TCP_TAG_MASK_8K
		: TCP_TAG_MASK_4K; // [R16]
	wire logic [3:0] set_idx = page_8k_in
		? la[TCP_SET_LSB_8K +: TCP_SET_W]
		: la[TCP_SET_LSB_4K +: TCP_SET_W]; // [R21]
	wire logic [19:0] req_tag = la[31:TCP_PAGE_LSB];
	wire logic accept = req_valid_in && state == TCP_ST_IDLE;

	logic [3:0] way_hit;
	logic [3:0] way_valid;
	tcp_entry_s way_ent [TCP_WAYS];

	genvar gw;
	generate
		for (gw = 0; gw < TCP_WAYS; gw++) begin : g_way
			localparam logic [1:0] WAY = 2'(gw);
			assign way_ent[gw] = ent[{set_idx, WAY}]; // [R11]
			assign way_valid[gw] = way_ent[gw].valid;
			assign way_hit[gw] = way_ent[gw].valid
				&& way_ent[gw].privilege_function_bit == req_fc2
				&& ((way_ent[gw].tag ^ req_tag) & tag_mask)
				== 20'h00000; // [R14] [R16]
		end
	endgenerate

	wire logic any_hit = |way_hit;
	wire logic [1:0] hit_way = way_hit[3] ? 2'h3 : way_hit[2] ? 2'h2
		: way_hit[1] ? 2'h1 : 2'h0;
	wire tcp_entry_s hit_ent = way_ent[hit_way];
	wire logic [1:0] free_way = !way_valid[0] ? 2'h0
		: !way_valid[1] ? 2'h1 : !way_valid[2] ? 2'h2 : 2'h3;
	wire logic set_full = &way_valid;

	// Protection checks on a hit
	wire logic super_viol = !req_fc2
		&& hit_ent.attr.supervisor_only; // [R6] [R7]
	wire logic write_viol = req_in.write
		&& hit_ent.attr.write_protect; // [R8] [R10]
	wire logic hit_error = super_viol || write_viol;
	wire logic not_resident = !hit_ent.attr.resident;
	wire logic need_mod = req_in.write && !hit_ent.attr.modified
		&& !hit_error && hit_ent.attr.resident; // [R18] [R25]
	wire logic hit_ok = !hit_error && !not_resident
		&& !need_mod; // [R25]
	wire logic bypass = req_in.alternate_space_move; // [R4]
	wire logic start_search = accept && !bypass
		&& (!any_hit || need_mod);

	// Physical address forming
	wire logic [31:0] hit_pa = page_8k_in
		? {hit_ent.attr.phys_page[19:1], la[12:0]}
		: {hit_ent.attr.phys_page, la[11:0]}; // [R20]
	wire logic [1:0] hit_cm = hit_ent.attr.cache_mode_field;

	// Fill target on search completion
	wire logic [3:0] pend_set = page_8k_in
		? pend_la[TCP_SET_LSB_8K +: TCP_SET_W]
		: pend_la[TCP_SET_LSB_4K +: TCP_SET_W]; // [R21]
	logic [3:0] pend_valid;
	generate
		for (gw = 0; gw < TCP_WAYS; gw++) begin : g_pend
			localparam logic [1:0] PWAY = 2'(gw);
			assign pend_valid[gw] = ent[{pend_set, PWAY}].valid;
		end
	endgenerate
	wire logic [1:0] pend_free = !pend_valid[0] ? 2'h0
		: !pend_valid[1] ? 2'h1 : !pend_valid[2] ? 2'h2 : 2'h3;
	wire logic [1:0] fill_way = pend_update ? pend_way
		: (&pend_valid) ? victim_cnt : pend_free; // [R18] [R22]
	wire logic [5:0] fill_idx = {pend_set, fill_way};
	wire logic do_fill = state == TCP_ST_SEARCH && search_done_in;
	wire logic [5:0] mod_idx = {set_idx, hit_way};
	wire logic do_mod = accept && !bypass && any_hit && hit_ok
		&& req_in.write;

	wire tcp_entry_s fill_ent = '{
		valid: 1'b1, // [R23]
		privilege_function_bit: pend_fc2, // [R14]
		tag: pend_la[31:TCP_PAGE_LSB], // [R12]
		attr: search_result_in // [R5] [R9] [R19] [R2]
	};

	// Flush selection per entry
	wire logic [19:0] flush_tag = flush_in.logical_addr[31:TCP_PAGE_LSB];

	// *******************************************************
	// Next response
	// *******************************************************
	tcp_resp_s next_resp;
	always_comb begin
		next_resp = '0;
		if (bypass) begin
			next_resp.hit = 1'b1;
			next_resp.phys_addr = la; // [R4]
			next_resp.cache_mode_field = TCP_CM_NONCACHE;
		end else if (any_hit && hit_error) begin
			next_resp.access_error = 1'b1; // [R6] [R10]
		end else if (any_hit && not_resident) begin
			next_resp.bus_error = 1'b1; // [R19]
		end else if (any_hit && !need_mod) begin
			next_resp.hit = 1'b1;
			next_resp.phys_addr = hit_pa; // [R20]
			next_resp.cache_mode_field = hit_cm;
		end else begin
			next_resp.retry = 1'b1; // [R18]
		end
		next_resp.cachable = next_resp.hit
			&& (next_resp.cache_mode_field == TCP_CM_WRITE_THROUGH
			|| next_resp.cache_mode_field == TCP_CM_COPYBACK); // [R13]
		next_resp.copyback = next_resp.hit
			&& next_resp.cache_mode_field == TCP_CM_COPYBACK; // [R13]
		next_resp.serialized = next_resp.hit
			&& next_resp.cache_mode_field == TCP_CM_NC_SERIAL; // [R13]
	end

	wire tcp_search_s next_search = '{
		logical_addr: la,
		root_pointer: req_fc2 ? supervisor_root_pointer_in
			: user_root_pointer_in, // [R1] [R3]
		supervisor: req_fc2,
		write: req_in.write
	};
	wire logic next_user_page_attr_out0 = accept && !bypass && any_hit && hit_ok
		&& req_in.ext_bus_xfer && hit_ent.attr.user_attr_bit0; // [R24]
	wire logic next_user_page_attr_out1 = accept && !bypass && any_hit && hit_ok
		&& req_in.ext_bus_xfer && hit_ent.attr.user_attr_bit1; // [R24]

	// *******************************************************
	// Control and outputs
	// *******************************************************
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			state <= TCP_ST_IDLE;
			victim_cnt <= TCP_RESET_VICTIM;
			pend_la <= '0;
			pend_fc2 <= 1'b0;
			pend_update <= 1'b0;
			pend_way <= 2'h0;
			busy_out <= 1'b0;
			resp_valid_out <= 1'b0;
			resp_out <= '0;
			search_req_out <= 1'b0;
			search_out <= '0;
			user_page_attr_out0 <= 1'b0;
			user_page_attr_out1 <= 1'b0;
		end else begin
			resp_valid_out <= accept;
			search_req_out <= start_search;
			user_page_attr_out0 <= next_user_page_attr_out0;
			user_page_attr_out1 <= next_user_page_attr_out1;
			if (accept) begin
				resp_out <= next_resp;
				victim_cnt <= victim_cnt + 2'h1; // [R22]
			end
			unique case (state)
				TCP_ST_IDLE: begin
					if (start_search) begin
						state <= TCP_ST_SEARCH;
						busy_out <= 1'b1;
						search_out <= next_search; // [R3]
						pend_la <= la;
						pend_fc2 <= req_fc2;
						pend_update <= any_hit; // [R18]
						pend_way <= hit_way;
					end
				end
				TCP_ST_SEARCH: begin
					if (search_done_in) begin
						state <= TCP_ST_IDLE;
						busy_out <= 1'b0;
					end
				end
			endcase
		end
	end

	// *******************************************************
	// Entry storage, fill, modify and flush
	// *******************************************************
	always_ff @(posedge clk_sys_in) begin
		if (sys_rst_in) begin
			for (int i = 0; i < TCP_ENTRIES; i++) begin
				ent[i] <= '0;
			end
		end else begin
			if (do_mod) begin
				ent[mod_idx].attr.modified <= 1'b1; // [R17]
			end
			if (do_fill) begin
				ent[fill_idx] <= fill_ent; // [R12] [R18]
			end
			if (flush_valid_in) begin
				for (int i = 0; i < TCP_ENTRIES; i++) begin
					if ((flush_in.all
						|| (ent[i].privilege_function_bit
						== flush_in.privilege_function_bit
						&& ((ent[i].tag ^ flush_tag) & tag_mask)
						== 20'h00000))
						&& !(flush_in.nonglobal_only
						&& ent[i].attr.global)) begin // [R15]
						ent[i].valid <= 1'b0; // [R23]
					end
				end
			end
		end
	end

endmodule : tcp_translation_cache
